// File: rtl/uhc_cap_pkg.sv
// package for the high-speed host capability register bank
package uhc_cap_pkg;

   // ***********************************************************
   // bus widths
   // ***********************************************************
   localparam int unsigned ADDR_W   = 8;
   localparam int unsigned DATA_W   = 32;
   localparam int unsigned ROUTE_W  = 4;
   localparam int unsigned MAX_PORT = 15;

   // ***********************************************************
   // register offsets (bytes from the memory base)
   // ***********************************************************
   localparam logic [7:0] OFS_LEN_VER = 8'h00;
   localparam logic [7:0] OFS_STRUCT  = 8'h04;
   localparam logic [7:0] OFS_CAPPAR  = 8'h08;

   // ***********************************************************
   // field positions
   // ***********************************************************
   localparam int unsigned LEN_LSB    = 0;
   localparam int unsigned VER_LSB    = 8;
   localparam int unsigned DPN_LSB    = 20;
   localparam int unsigned PIND_BIT   = 16;
   localparam int unsigned NCC_LSB    = 12;
   localparam int unsigned NPCC_LSB   = 8;
   localparam int unsigned PRR_BIT    = 7;
   localparam int unsigned PPC_BIT    = 4;
   localparam int unsigned NPORTS_LSB = 0;
   localparam int unsigned IST_LSB    = 4;
   localparam int unsigned IST_FRAME  = 3;
   localparam int unsigned PROGRAMMABLE_FRAME_LIST_FLAG_BIT   = 1;
   localparam int unsigned WIDE_BIT   = 0;

   // ***********************************************************
   // documented field values
   // ***********************************************************
   localparam logic [7:0]  RST_CAP_LENGTH = 8'h0C;
   localparam logic [15:0] RST_VERSION    = 16'h9500;
   localparam logic [3:0]  RST_DPN        = 4'h0;
   localparam logic        RST_PIND       = 1'b0;
   localparam logic [3:0]  RST_NCC        = 4'h2;
   localparam logic [3:0]  RST_NPCC       = 4'h2;
   localparam logic        RST_PRR        = 1'b0;
   localparam logic        RST_PPC        = 1'b1;
   localparam logic [3:0]  RST_NPORTS     = 4'h4;
   localparam logic [3:0]  RST_IST        = 4'h1;
   localparam logic        RST_PROGRAMMABLE_FRAME_LIST_FLAG       = 1'b1;
   localparam logic        RST_WIDE       = 1'b0;

   // ***********************************************************
   // frame list size encodings and lengths
   // ***********************************************************
   localparam logic [1:0]  FLS_1024 = 2'h0;
   localparam logic [1:0]  FLS_512  = 2'h1;
   localparam logic [1:0]  FLS_256  = 2'h2;
   localparam logic [1:0]  FLS_RSVD = 2'h3;
   localparam logic [10:0] LEN_1024 = 11'h400;
   localparam logic [10:0] LEN_512  = 11'h200;
   localparam logic [10:0] LEN_256  = 11'h100;

   // ***********************************************************
   // carriers
   // ***********************************************************
   typedef struct packed {
      logic              valid;
      logic              write;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
   } uhc_req_t;

   typedef struct packed {
      logic              ack;
      logic [DATA_W-1:0] rdata;
   } uhc_rsp_t;

   typedef struct packed {
      uhc_rsp_t           rsp;
      logic [1:0]         frame_list_size;
      logic [10:0]        flen;
      logic [ROUTE_W-1:0] comp;
      logic               route_ok;
   } uhc_state_t;

endpackage

// File: rtl/uhc_cap_regs.sv
// read-only capability register bank of the high-speed host function
`timescale 1ns/1ns
`default_nettype none

module uhc_cap_regs #(
   parameter logic [7:0]  CAP_LENGTH  = uhc_cap_pkg::RST_CAP_LENGTH,
   parameter logic [15:0] IF_VERSION  = uhc_cap_pkg::RST_VERSION,
   parameter logic [3:0]  DEBUG_PORT  = uhc_cap_pkg::RST_DPN,
   parameter logic        PORT_IND    = uhc_cap_pkg::RST_PIND,
   parameter logic [3:0]  COMP_COUNT  = uhc_cap_pkg::RST_NCC,
   parameter logic [3:0]  PORTS_PER_C = uhc_cap_pkg::RST_NPCC,
   parameter logic        ROUTE_RULE  = uhc_cap_pkg::RST_PRR,
   parameter logic        PWR_SWITCH  = uhc_cap_pkg::RST_PPC,
   parameter logic [3:0]  PORT_COUNT  = uhc_cap_pkg::RST_NPORTS,
   parameter logic [3:0]  ISO_THRESH  = uhc_cap_pkg::RST_IST,
   parameter logic        PROG_FLIST  = uhc_cap_pkg::RST_PROGRAMMABLE_FRAME_LIST_FLAG,
   parameter logic        WIDE_ADDR   = uhc_cap_pkg::RST_WIDE
) (
   input  wire logic                   core_clk_i,
   input  wire logic                   rst_b_i,
   input  wire uhc_cap_pkg::uhc_req_t  req_i,
   output var  uhc_cap_pkg::uhc_rsp_t  rsp_o,
   input  wire logic                   fls_wr_i,
   input  wire logic [1:0]             fls_wdata_i,
   output logic [1:0]                  frame_list_size_o,
   output logic [10:0]                 frame_list_len_o,
   input  wire logic [3:0]             route_port_i,
   input  wire logic [59:0]            port_route_array_i,
   output logic [3:0]                  route_companion_o,
   output logic                        route_valid_o,
   output logic                        handoff_supported_o,
   output logic                        debug_port_present_o,
   output logic                        port_indicator_ctl_o,
   output logic                        port_power_switched_o,
   output logic                        iso_whole_frame_o,
   output logic [2:0]                  iso_uframes_o
);

   // ***********************************************************
   // constant register images
   // ***********************************************************
   localparam logic [31:0] WORD_LEN_VER =
      (32'(CAP_LENGTH) << uhc_cap_pkg::LEN_LSB) |
      (32'(IF_VERSION) << uhc_cap_pkg::VER_LSB);

   localparam logic [31:0] WORD_STRUCT =
      (32'(DEBUG_PORT)  << uhc_cap_pkg::DPN_LSB)    |
      (32'(PORT_IND)    << uhc_cap_pkg::PIND_BIT)   |
      (32'(COMP_COUNT)  << uhc_cap_pkg::NCC_LSB)    |
      (32'(PORTS_PER_C) << uhc_cap_pkg::NPCC_LSB)   |
      (32'(ROUTE_RULE)  << uhc_cap_pkg::PRR_BIT)    |
      (32'(PWR_SWITCH)  << uhc_cap_pkg::PPC_BIT)    |
      (32'(PORT_COUNT)  << uhc_cap_pkg::NPORTS_LSB);

   localparam logic [31:0] WORD_CAPPAR =
      (32'(ISO_THRESH) << uhc_cap_pkg::IST_LSB)  |
      (32'(PROG_FLIST) << uhc_cap_pkg::PROGRAMMABLE_FRAME_LIST_FLAG_BIT) |
      (32'(WIDE_ADDR)  << uhc_cap_pkg::WIDE_BIT);

   // ***********************************************************
   // helpers
   // ***********************************************************
   // read decode; anything unmapped or a write answers zero
   function automatic logic [31:0] read_word(input logic [7:0] addr);
      logic [31:0] w;
      w = '0;
      if (addr == uhc_cap_pkg::OFS_LEN_VER) begin
         w = WORD_LEN_VER;
      end else if (addr == uhc_cap_pkg::OFS_STRUCT) begin
         w = WORD_STRUCT;
      end else if (addr == uhc_cap_pkg::OFS_CAPPAR) begin
         w = WORD_CAPPAR;
      end
      return w;
   endfunction

   // companion for a zero-based port index
   function automatic logic [3:0] route_of(input logic [3:0]  port,
                                           input logic [59:0] arr);
      logic [3:0] c;
      c = '0;
      if (ROUTE_RULE) begin
         c = arr[port*uhc_cap_pkg::ROUTE_W +: uhc_cap_pkg::ROUTE_W];
      end else if (PORTS_PER_C != 4'h0) begin
         c = port / PORTS_PER_C;
      end
      return c;
   endfunction

   function automatic logic [10:0] list_len(input logic [1:0] frame_list_size);
      logic [10:0] n;
      n = uhc_cap_pkg::LEN_1024;
      if (frame_list_size == uhc_cap_pkg::FLS_512) begin
         n = uhc_cap_pkg::LEN_512;
      end else if (frame_list_size == uhc_cap_pkg::FLS_256) begin
         n = uhc_cap_pkg::LEN_256;
      end
      return n;
   endfunction

   // ***********************************************************
   // state
   // ***********************************************************
   uhc_cap_pkg::uhc_state_t state_r;
   uhc_cap_pkg::uhc_state_t state_nxt;

   always_comb begin
      state_nxt              = state_r;
      // every access is answered one clock later; writes change nothing
      state_nxt.rsp.ack      = req_i.valid;
      state_nxt.rsp.rdata    = '0;
      if (req_i.valid && !req_i.write) begin
         state_nxt.rsp.rdata = read_word(req_i.addr);
      end
      // reserved size code is dropped so the list length stays defined
      if (!PROG_FLIST) begin
         state_nxt.frame_list_size = uhc_cap_pkg::FLS_1024;
      end else if (fls_wr_i && fls_wdata_i != uhc_cap_pkg::FLS_RSVD) begin
         state_nxt.frame_list_size = fls_wdata_i;
      end
      state_nxt.flen     = list_len(state_nxt.frame_list_size);
      state_nxt.comp     = route_of(route_port_i, port_route_array_i);
      state_nxt.route_ok = (route_port_i < PORT_COUNT) && (COMP_COUNT != 4'h0);
   end

   always_ff @(posedge core_clk_i) begin
      if (!rst_b_i) begin
         state_r <= '0;
      end else begin
         state_r <= state_nxt;
      end
   end

   // ***********************************************************
   // outputs
   // ***********************************************************
   assign rsp_o                 = state_r.rsp;
   assign frame_list_size_o     = state_r.frame_list_size;
   assign frame_list_len_o      = state_r.flen;
   assign route_companion_o     = state_r.comp;
   assign route_valid_o         = state_r.route_ok;
   assign handoff_supported_o   = (COMP_COUNT != 4'h0);
   assign debug_port_present_o  = (DEBUG_PORT != 4'h0) && (DEBUG_PORT <= PORT_COUNT);
   assign port_indicator_ctl_o  = PORT_IND;
   assign port_power_switched_o = PWR_SWITCH;
   assign iso_whole_frame_o     = ISO_THRESH[uhc_cap_pkg::IST_FRAME];
   assign iso_uframes_o         = ISO_THRESH[uhc_cap_pkg::IST_FRAME] ? 3'h0
                                                                     : ISO_THRESH[2:0];

   // ***********************************************************
   // assertions
   // ***********************************************************
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (!rst_b_i);

   property p_ack_one_cycle;
      req_i.valid |=> rsp_o.ack ##1 (rsp_o.ack == $past(req_i.valid));
   endproperty
   a_ack_one_cycle: assert property (p_ack_one_cycle) else $error("ack not one cycle after request");

   property p_cap_length;
      req_i.valid && !req_i.write && req_i.addr == uhc_cap_pkg::OFS_LEN_VER
         |=> rsp_o.rdata[7:0] == CAP_LENGTH && rsp_o.rdata[31:24] == 8'h00;
   endproperty
   a_cap_length: assert property (p_cap_length) else $error("capability length wrong");

   property p_version;
      req_i.valid && !req_i.write && req_i.addr == uhc_cap_pkg::OFS_LEN_VER
         |=> rsp_o.rdata[23:8] == IF_VERSION;
   endproperty
   a_version: assert property (p_version) else $error("interface version wrong");

   property p_struct_word;
      req_i.valid && !req_i.write && req_i.addr == uhc_cap_pkg::OFS_STRUCT
         |=> rsp_o.rdata[3:0] == PORT_COUNT && rsp_o.rdata[11:8] == PORTS_PER_C
             && rsp_o.rdata[15:12] == COMP_COUNT && rsp_o.rdata[4] == PWR_SWITCH
             && rsp_o.rdata[31:24] == 8'h00 && rsp_o.rdata[6:5] == 2'h0;
   endproperty
   a_struct_word: assert property (p_struct_word) else $error("structural word wrong");

   property p_cappar_word;
      req_i.valid && !req_i.write && req_i.addr == uhc_cap_pkg::OFS_CAPPAR
         |=> rsp_o.rdata[0] == WIDE_ADDR && rsp_o.rdata[7:4] == ISO_THRESH
             && rsp_o.rdata[31:8] == 24'h000000;
   endproperty
   a_cappar_word: assert property (p_cappar_word) else $error("capability word wrong");

   property p_write_ignored;
      req_i.valid && req_i.write |=> rsp_o.ack && rsp_o.rdata == 32'h00000000;
   endproperty
   a_write_ignored: assert property (p_write_ignored) else $error("write had an effect");

   property p_fls_fixed;
      !PROG_FLIST |-> ##1 frame_list_size_o == uhc_cap_pkg::FLS_1024
                     && frame_list_len_o == uhc_cap_pkg::LEN_1024;
   endproperty
   a_fls_fixed: assert property (p_fls_fixed) else $error("fixed frame list size moved");

   // length is registered from the same next value, so both move at one edge
   property p_fls_accept;
      PROG_FLIST && fls_wr_i && fls_wdata_i != uhc_cap_pkg::FLS_RSVD
         |=> frame_list_size_o == $past(fls_wdata_i)
             && frame_list_len_o == list_len($past(fls_wdata_i));
   endproperty
   a_fls_accept: assert property (p_fls_accept) else $error("frame list size not taken");

   property p_route_groups;
      !ROUTE_RULE && PORTS_PER_C != 4'h0
         |=> route_companion_o == 4'($past(route_port_i) / PORTS_PER_C);
   endproperty
   a_route_groups: assert property (p_route_groups) else $error("grouped routing wrong");

   property p_route_array;
      ROUTE_RULE |=> route_companion_o ==
         $past(port_route_array_i[route_port_i*uhc_cap_pkg::ROUTE_W +: uhc_cap_pkg::ROUTE_W]);
   endproperty
   a_route_array: assert property (p_route_array) else $error("explicit routing wrong");

   property p_debug_range;
      debug_port_present_o |-> DEBUG_PORT <= PORT_COUNT && PORT_COUNT != 4'h0;
   endproperty
   a_debug_range: assert property (p_debug_range) else $error("debug port beyond port count");

   property p_handoff;
      handoff_supported_o == (COMP_COUNT != 4'h0) && route_valid_o |-> COMP_COUNT != 4'h0;
   endproperty
   a_handoff: assert property (p_handoff) else $error("hand-off flag inconsistent");

   c_read_struct: cover property (req_i.valid && !req_i.write
                                  && req_i.addr == uhc_cap_pkg::OFS_STRUCT ##1 rsp_o.ack);
   c_write_any:   cover property (req_i.valid && req_i.write ##1 rsp_o.ack);
   c_fls_512:     cover property (fls_wr_i && fls_wdata_i == uhc_cap_pkg::FLS_512
                                  ##1 frame_list_size_o == uhc_cap_pkg::FLS_512);
   c_route_last:  cover property (route_port_i == PORT_COUNT - 4'h1 ##1 route_valid_o);

endmodule

`default_nettype wire

// File: tb/uhc_cap_regs_tb.sv
// self-checking bench for the capability register bank, default and alternate builds
`timescale 1ns/1ns
`default_nettype none

module uhc_cap_regs_tb;
   // ***********************************************************
   // alternate build: debug port, explicit routing, fixed list
   // ***********************************************************
   localparam logic [3:0]  A_DPN  = 4'h3;
   localparam logic [3:0]  A_IST  = 4'h9;
   // entry n holds 14-n, so a reversed index shows up
   localparam logic [59:0] ROUTES = 60'h0123456789ABCDE;
   localparam logic [31:0] E0     = {8'h00, uhc_cap_pkg::RST_VERSION,
                                     uhc_cap_pkg::RST_CAP_LENGTH};
   localparam logic [31:0] E1B    = {8'h00, uhc_cap_pkg::RST_DPN, 3'h0, uhc_cap_pkg::RST_PIND,
                                     uhc_cap_pkg::RST_NCC, uhc_cap_pkg::RST_NPCC,
                                     uhc_cap_pkg::RST_PRR, 2'h0, uhc_cap_pkg::RST_PPC,
                                     uhc_cap_pkg::RST_NPORTS};
   localparam logic [31:0] E1A    = {8'h00, A_DPN, 3'h0, 1'h1, uhc_cap_pkg::RST_NCC,
                                     uhc_cap_pkg::RST_NPCC, 1'h1, 2'h0, 1'h0,
                                     uhc_cap_pkg::RST_NPORTS};
   localparam logic [31:0] E2B    = {24'h0, uhc_cap_pkg::RST_IST, 2'h0, uhc_cap_pkg::RST_PROGRAMMABLE_FRAME_LIST_FLAG,
                                     uhc_cap_pkg::RST_WIDE};
   localparam logic [31:0] E2A    = {24'h0, A_IST, 2'h0, 1'h0, 1'h1};

   logic                  core_clk;
   logic                  rst_b;
   uhc_cap_pkg::uhc_req_t req;
   uhc_cap_pkg::uhc_rsp_t rsp [2];
   logic                  fls_wr;
   logic [1:0]            fls_wd;
   logic [1:0]            size [2];
   logic [10:0]           len [2];
   logic [3:0]            port;
   logic [3:0]            comp [2];
   logic                  rv [2];
   logic [7:0]            flg [2];
   int                    bad_count = 0;
   int                    compares = 0;
   int                    cycles = 0;

   // both builds share every input; only their answers differ
   for (genvar g = 0; g < 2; g++) begin : g_dut
      uhc_cap_regs #(
         .DEBUG_PORT (g ? A_DPN : uhc_cap_pkg::RST_DPN),
         .PORT_IND   (g ? 1'h1 : uhc_cap_pkg::RST_PIND),
         .ROUTE_RULE (g ? 1'h1 : uhc_cap_pkg::RST_PRR),
         .PWR_SWITCH (g ? 1'h0 : uhc_cap_pkg::RST_PPC),
         .ISO_THRESH (g ? A_IST : uhc_cap_pkg::RST_IST),
         .PROG_FLIST (g ? 1'h0 : uhc_cap_pkg::RST_PROGRAMMABLE_FRAME_LIST_FLAG),
         .WIDE_ADDR  (g ? 1'h1 : uhc_cap_pkg::RST_WIDE)
      ) uhc_cap_regs_i (
         .core_clk_i            (core_clk),
         .rst_b_i               (rst_b),
         .req_i                 (req),
         .rsp_o                 (rsp[g]),
         .fls_wr_i              (fls_wr),
         .fls_wdata_i           (fls_wd),
         .frame_list_size_o     (size[g]),
         .frame_list_len_o      (len[g]),
         .route_port_i          (port),
         .port_route_array_i    (ROUTES),
         .route_companion_o     (comp[g]),
         .route_valid_o         (rv[g]),
         .handoff_supported_o   (flg[g][7]),
         .debug_port_present_o  (flg[g][6]),
         .port_indicator_ctl_o  (flg[g][5]),
         .port_power_switched_o (flg[g][4]),
         .iso_whole_frame_o     (flg[g][3]),
         .iso_uframes_o         (flg[g][2:0])
      );
   end

   initial begin
      core_clk = 1'h0;
      forever #10 core_clk = ~core_clk;
   end

   // ***********************************************************
   // shared tasks
   // ***********************************************************
   task automatic end_of_test;
      $display("compares %0d mismatches %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      compares++;
      if (got !== exp) begin
         $display("FAIL %s expected %h seen %h", name, exp, got);
         bad_count++;
      end
   endtask

   // one access, answer checked one edge after it is taken, then gone
   task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] x0,
                      input logic [31:0] x1);
      @(posedge core_clk);
      req <= '{valid: 1'h1, write: w, addr: a, wdata: 32'hFFFFFFFF};
      @(posedge core_clk);
      req.valid <= 1'h0;
      @(posedge core_clk);
      for (int i = 0; i < 2; i++) begin
         chk("ack", 32'h1, {31'h0, rsp[i].ack});
         chk("rdata", i ? x1 : x0, rsp[i].rdata);
      end
      @(posedge core_clk);
      chk("ack after", 32'h0, {31'h0, rsp[0].ack});
   endtask

   task automatic frame_list_size(input logic [1:0] code, input logic [1:0] xs, input logic [10:0] xl);
      @(posedge core_clk);
      fls_wr <= 1'h1;
      fls_wd <= code;
      @(posedge core_clk);
      fls_wr <= 1'h0;
      @(posedge core_clk);
      chk("size", {30'h0, xs}, {30'h0, size[0]});
      chk("size fixed", 32'h0, {30'h0, size[1]});
      @(posedge core_clk);
      chk("length", {21'h0, xl}, {21'h0, len[0]});
      chk("length fixed", {21'h0, uhc_cap_pkg::LEN_1024}, {21'h0, len[1]});
   endtask

   task automatic rte(input logic [3:0] p);
      @(posedge core_clk);
      port <= p;
      repeat (2) @(posedge core_clk);
      chk("grouped", {28'h0, p / uhc_cap_pkg::RST_NPCC}, {28'h0, comp[0]});
      chk("listed", {28'h0, ROUTES[4*int'(p) +: 4]}, {28'h0, comp[1]});
      for (int i = 0; i < 2; i++) begin
         chk("in range", {31'h0, p < uhc_cap_pkg::RST_NPORTS}, {31'h0, rv[i]});
      end
   endtask

   // a hang cuts the run short through the same closing report
   always @(posedge core_clk) begin
      cycles <= cycles + 1;
      if (cycles == 2000) begin
         bad_count++;
         $display("FAIL timeout expected done seen hang");
         end_of_test();
      end
   end

   // ***********************************************************
   // tests
   // ***********************************************************
   initial begin
      rst_b = 1'h0;
      req = '0;
      fls_wr = 1'h0;
      fls_wd = 2'h0;
      port = 4'h0;
      repeat (4) @(posedge core_clk);
      chk("reset ack", 32'h0, {31'h0, rsp[0].ack});
      chk("reset size", 32'h0, {30'h0, size[0]});
      rst_b <= 1'h1;
      @(posedge core_clk);
      $display("test reset done");
      acc(1'h0, uhc_cap_pkg::OFS_LEN_VER, E0, E0);
      acc(1'h0, uhc_cap_pkg::OFS_STRUCT, E1B, E1A);
      acc(1'h0, uhc_cap_pkg::OFS_CAPPAR, E2B, E2A);
      acc(1'h0, 8'h0C, 32'h0, 32'h0);
      acc(1'h1, uhc_cap_pkg::OFS_STRUCT, 32'h0, 32'h0);
      acc(1'h0, uhc_cap_pkg::OFS_STRUCT, E1B, E1A);
      // back-to-back reads give back-to-back answers in order
      @(posedge core_clk);
      req <= '{valid: 1'h1, write: 1'h0, addr: uhc_cap_pkg::OFS_LEN_VER, wdata: 32'h0};
      @(posedge core_clk);
      req.addr <= uhc_cap_pkg::OFS_CAPPAR;
      @(posedge core_clk);
      req.valid <= 1'h0;
      chk("first of pair", E0, rsp[0].rdata);
      @(posedge core_clk);
      chk("second of pair", E2B, rsp[0].rdata);
      $display("test register reads done");
      // flags: handoff, debug, indicator, power, whole frame, microframes
      chk("flags default", 32'h91, {24'h0, flg[0]});
      chk("flags alternate", 32'hE8, {24'h0, flg[1]});
      $display("test decoded flags done");
      // list base alignment is left to software; only sizes are driven here
      frame_list_size(2'h1, 2'h1, uhc_cap_pkg::LEN_512);
      frame_list_size(2'h2, 2'h2, uhc_cap_pkg::LEN_256);
      frame_list_size(2'h3, 2'h2, uhc_cap_pkg::LEN_256);
      frame_list_size(2'h0, 2'h0, uhc_cap_pkg::LEN_1024);
      $display("test frame list size done");
      for (int p = 0; p < 6; p++) begin
         rte(4'(p));
      end
      rte(4'hE);
      $display("test routing done");
      end_of_test();
   end
endmodule

`default_nettype wire
